/* core/mcuis_consts.svh */
// constants for the instruction execution block
`ifndef MCUIS_CONSTS_SVH
`define MCUIS_CONSTS_SVH
`define MCUIS_DATA_W 8
`define MCUIS_PC_W 13
`define MCUIS_STACK_DEPTH 8
`define MCUIS_PC_RST 13'h0000
`define MCUIS_ACC_RST 8'h00
`define MCUIS_WDT_W 16
`define MCUIS_PRE_W 8
`define MCUIS_BCD_LO 8'h06
`define MCUIS_BCD_HI 8'h60
`define MCUIS_NIB_MAX 4'h9
`define MCUIS_IRQ_VEC 13'h0004
`endif

/* core/mcuis_pkg.sv */
// types for the instruction execution block
`include "mcuis_consts.svh"
package mcuis_pkg;
  typedef enum logic [4:0] {
    OP_NOP = 5'h00, OP_ADC = 5'h01, OP_ADD = 5'h02, OP_AND = 5'h03, OP_OR = 5'h04,
    OP_CALL = 5'h05, OP_CLR = 5'h06, OP_CLRB = 5'h07, OP_WDTCLR = 5'h08, OP_CPL = 5'h09,
    OP_DAA = 5'h0A, OP_DEC = 5'h0B, OP_INC = 5'h0C, OP_HALT = 5'h0D, OP_JMP = 5'h0E,
    OP_MOVA = 5'h0F, OP_MOVM = 5'h10, OP_RET = 5'h11, OP_INTERRUPT_RETURN = 5'h12
  } mcuis_op_t;
  typedef struct packed {
    logic valid;
    mcuis_op_t op;
    logic to_mem;
    logic use_imm;
    logic [7:0] imm;
    logic [2:0] bit_sel;
    logic [12:0] target;
  } mcuis_instr_t;
  typedef struct packed {
    logic overflow_flag;
    logic zero_flag;
    logic half_carry_flag;
    logic carry_flag;
    logic secondary_compare_flag;
  } mcuis_flags_t;
  typedef enum logic [2:0] {
    ST_EXEC = 3'b001,
    ST_DUMMY = 3'b010,
    ST_HALTED = 3'b100
  } mcuis_state_t;
endpackage

/* core/mcuis_stack.sv */
// return address stack with registered read data
`timescale 1ns/1ps
`default_nettype none
`include "mcuis_consts.svh"
module mcuis_stack
  import mcuis_pkg::*;
#(
  parameter int DEPTH = `MCUIS_STACK_DEPTH,
  parameter int W = `MCUIS_PC_W
)
(
  input wire logic clk, // clock
  input wire logic rst_b, // sync reset
  input wire logic push, // push request
  input wire logic pop, // pop request
  input wire logic [W-1:0] wdata, // pushed value
  output logic [W-1:0] rdata // top of stack, registered
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] sp_ff;
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      sp_ff <= '0;
    else if (push)
      sp_ff <= sp_ff + AW'(1);
    else if (pop)
      sp_ff <= sp_ff - AW'(1);
  end
  always_ff @(posedge clk)
  begin
    if (push)
      mem[sp_ff] <= wdata;
  end
  // read data tracks the top entry, so a pop sees it without extra cycle
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      rdata <= '0;
    else if (push)
      rdata <= wdata;
    else if (pop)
      rdata <= mem[sp_ff - AW'(2)];
    else
      rdata <= mem[sp_ff - AW'(1)];
  end
endmodule
`default_nettype wire

/* core/mcuis_core.sv */
// instruction execution core: alu, flags, program counter, stack, power control
`timescale 1ns/1ps
`default_nettype none
`include "mcuis_consts.svh"
// Operation
// [RULE1] add with carry: acc plus operand plus carry; five arithmetic flags updated
// [RULE2] plain add of memory or immediate, no carry in; five flags updated
// [RULE3] and with memory or immediate; only zero flag changes
// [RULE4] or with memory or immediate; only zero flag changes
// [RULE5] call pushes pc plus one, loads target; two cycles; no flags
// [RULE6] clear writes zero byte; bit clear zeroes one bit; no flags
// [RULE7] watchdog clear resets counter, clears timeout and power-down flags
// [RULE8] complement inverts operand to memory or accumulator; zero flag updated
// [RULE9] decimal adjust adds six per nibble over nine or flagged; result to memory
// [RULE10] decimal adjust changes only carry, set when decimal sum passes hundred
// [RULE11] decrement operand to memory or accumulator; zero flag updated
// [RULE12] increment operand to memory or accumulator; zero flag updated
// [RULE13] halt stops execution, clears watchdog and prescaler, sets power-down
// [RULE14] jump loads target with one dummy cycle; no flags
// [RULE15] move memory or immediate to accumulator, or accumulator to memory
// [RULE16] no operation only advances the program counter
// [RULE17] return pops pc; immediate form loads accumulator; no flags
// [RULE18] interrupt return pops pc and sets global interrupt enable
// [RULE19] pending interrupt at interrupt return is serviced before main program
// [RULE20] all other instructions here except halt complete in one cycle; return and interrupt return also take two cycles here, via the dummy state
module mcuis_core
  import mcuis_pkg::*;
#(
  parameter int STACK_DEPTH = `MCUIS_STACK_DEPTH
)
(
  input wire logic CLK, // clock
  input wire logic RST_B, // sync reset, active low
  input wire mcuis_instr_t INSTR, // decoded instruction from fetch
  input wire logic [7:0] MEM_RDATA, // operand byte read from data memory
  input wire logic IRQ_PENDING, // interrupt request pin
  input wire logic WAKE, // wake from halt pin
  output logic INSTR_READY, // core accepts INSTR this cycle
  output logic [12:0] PC, // program counter
  output logic [7:0] ACCUMULATOR, // accumulator
  output logic MEM_WE, // data memory write strobe
  output logic [7:0] MEM_WDATA, // data memory write byte
  output mcuis_flags_t FLAGS, // status flags
  output logic WATCHDOG_TIMEOUT_FLAG, // watchdog timeout flag
  output logic POWERDOWN_FLAG, // power-down flag
  output logic GLOBAL_IRQ_ENABLE, // master interrupt enable
  output logic CLK_GATE_OFF, // system clock gated off
  output logic [15:0] WATCHDOG_COUNTER, // watchdog count
  output logic IRQ_TAKEN // pulse when interrupt vector is entered
);
  mcuis_state_t state_ff;
  logic [12:0] pc_ff;
  logic [7:0] acc_ff;
  logic mem_we_ff;
  logic [7:0] mem_wdata_ff;
  mcuis_flags_t flags_ff;
  logic to_ff;
  logic pdf_ff;
  logic emi_ff;
  logic [15:0] wdt_ff;
  logic [7:0] pre_ff;
  logic irq_taken_ff;
  logic [1:0] irq_sync_ff;
  logic [1:0] wake_sync_ff;
  logic irq_s;
  logic wake_s;
  logic [12:0] stack_top;
  logic push;
  logic pop;
  logic [12:0] push_data;
  logic exec;
  logic take_irq;
  logic [7:0] opnd;
  logic [8:0] sum;
  logic [4:0] low_sum;
  logic [7:0] res;
  logic wr_acc;
  logic wr_mem;
  logic upd_arith;
  logic upd_zero;
  logic [7:0] daa_adj;
  logic [8:0] daa_sum;

  function automatic logic is_arith(input mcuis_op_t op);
    is_arith = (op == OP_ADC) || (op == OP_ADD);
  endfunction

  // pin inputs pass two flops first
  always_ff @(posedge CLK)
  begin
    if (!RST_B)
    begin
      irq_sync_ff <= '0;
      wake_sync_ff <= '0;
    end
    else
    begin
      irq_sync_ff <= {irq_sync_ff[0], IRQ_PENDING};
      wake_sync_ff <= {wake_sync_ff[0], WAKE};
    end
  end
  assign irq_s = irq_sync_ff[1];
  assign wake_s = wake_sync_ff[1];

  assign exec = (state_ff == ST_EXEC) && INSTR.valid && !take_irq;
  // interrupt entry wins over the next main-program instruction
  assign take_irq = (state_ff == ST_EXEC) && irq_s && emi_ff; // RULE19
  assign INSTR_READY = (state_ff == ST_EXEC) && !take_irq;

  assign opnd = INSTR.use_imm ? INSTR.imm : MEM_RDATA;
  assign sum = {1'b0, acc_ff} + {1'b0, opnd} + {8'h00, (INSTR.op == OP_ADC) & flags_ff.carry_flag}; // RULE1 RULE2
  assign low_sum = {1'b0, acc_ff[3:0]} + {1'b0, opnd[3:0]} + {4'h0, (INSTR.op == OP_ADC) & flags_ff.carry_flag};
  assign daa_adj = ((acc_ff[3:0] > `MCUIS_NIB_MAX) || flags_ff.half_carry_flag ? `MCUIS_BCD_LO : 8'h00)
    | ((acc_ff[7:4] > `MCUIS_NIB_MAX) || flags_ff.carry_flag ? `MCUIS_BCD_HI : 8'h00); // RULE9
  assign daa_sum = {1'b0, acc_ff} + {1'b0, daa_adj};

  always_comb
  begin
    res = 8'h00;
    wr_acc = 1'b0;
    wr_mem = 1'b0;
    upd_arith = 1'b0;
    upd_zero = 1'b0;
    case (INSTR.op)
      OP_ADC, OP_ADD:
      begin
        res = sum[7:0];
        wr_acc = !INSTR.to_mem;
        wr_mem = INSTR.to_mem;
        upd_arith = 1'b1; // RULE1 RULE2
      end
      OP_AND:
      begin
        res = acc_ff & opnd; // RULE3
        wr_acc = !INSTR.to_mem;
        wr_mem = INSTR.to_mem;
        upd_zero = 1'b1;
      end
      OP_OR:
      begin
        res = acc_ff | opnd; // RULE4
        wr_acc = !INSTR.to_mem;
        wr_mem = INSTR.to_mem;
        upd_zero = 1'b1;
      end
      OP_CLR:
      begin
        res = 8'h00; // RULE6
        wr_mem = 1'b1;
      end
      OP_CLRB:
      begin
        res = MEM_RDATA & ~(8'h01 << INSTR.bit_sel); // RULE6
        wr_mem = 1'b1;
      end
      OP_CPL:
      begin
        res = ~MEM_RDATA; // RULE8
        wr_acc = !INSTR.to_mem;
        wr_mem = INSTR.to_mem;
        upd_zero = 1'b1;
      end
      OP_DAA:
      begin
        res = daa_sum[7:0]; // RULE9
        wr_mem = 1'b1;
      end
      OP_DEC:
      begin
        res = MEM_RDATA - 8'h01; // RULE11
        wr_acc = !INSTR.to_mem;
        wr_mem = INSTR.to_mem;
        upd_zero = 1'b1;
      end
      OP_INC:
      begin
        res = MEM_RDATA + 8'h01; // RULE12
        wr_acc = !INSTR.to_mem;
        wr_mem = INSTR.to_mem;
        upd_zero = 1'b1;
      end
      OP_MOVA:
      begin
        res = opnd; // RULE15
        wr_acc = 1'b1;
      end
      OP_MOVM:
      begin
        res = acc_ff; // RULE15
        wr_mem = 1'b1;
      end
      OP_RET:
      begin
        res = INSTR.imm; // RULE17
        wr_acc = INSTR.use_imm;
      end
      default:
      begin
        res = 8'h00;
      end
    endcase
  end

  // sequencing: two-cycle ops go through a dummy state, halt parks the core
  always_ff @(posedge CLK)
  begin
    if (!RST_B)
      state_ff <= ST_EXEC;
    else
    begin
      case (state_ff)
        ST_EXEC:
        begin
          if (take_irq)
            state_ff <= ST_DUMMY;
          else if (exec && (INSTR.op == OP_CALL || INSTR.op == OP_JMP || INSTR.op == OP_RET
            || INSTR.op == OP_INTERRUPT_RETURN))
            state_ff <= ST_DUMMY; // RULE5 RULE14
          else if (exec && INSTR.op == OP_HALT)
            state_ff <= ST_HALTED; // RULE13
          else
            state_ff <= ST_EXEC; // RULE20
        end
        ST_DUMMY:
          state_ff <= ST_EXEC;
        ST_HALTED:
          if (wake_s)
            state_ff <= ST_EXEC;
        default:
          state_ff <= ST_EXEC;
      endcase
    end
  end

  assign push = take_irq || (exec && INSTR.op == OP_CALL); // RULE5
  assign push_data = take_irq ? pc_ff : pc_ff + 13'h0001; // RULE5
  assign pop = exec && (INSTR.op == OP_RET || INSTR.op == OP_INTERRUPT_RETURN); // RULE17 RULE18

  mcuis_stack #(
    .DEPTH(STACK_DEPTH),
    .W(`MCUIS_PC_W)
  ) u_stack (
    .clk(CLK),
    .rst_b(RST_B),
    .push(push),
    .pop(pop),
    .wdata(push_data),
    .rdata(stack_top)
  );

  always_ff @(posedge CLK)
  begin
    if (!RST_B)
      pc_ff <= `MCUIS_PC_RST;
    else if (take_irq)
      pc_ff <= `MCUIS_IRQ_VEC;
    else if (exec)
    begin
      case (INSTR.op)
        OP_CALL, OP_JMP:
          pc_ff <= INSTR.target; // RULE5 RULE14
        OP_RET, OP_INTERRUPT_RETURN:
          pc_ff <= stack_top; // RULE17 RULE18
        OP_HALT:
          pc_ff <= pc_ff + 13'h0001;
        default:
          pc_ff <= pc_ff + 13'h0001; // RULE16
      endcase
    end
  end

  always_ff @(posedge CLK)
  begin
    if (!RST_B)
      acc_ff <= `MCUIS_ACC_RST;
    else if (exec && wr_acc)
      acc_ff <= res; // RULE15 RULE17
  end

  always_ff @(posedge CLK)
  begin
    if (!RST_B)
    begin
      mem_we_ff <= 1'b0;
      mem_wdata_ff <= 8'h00;
    end
    else
    begin
      mem_we_ff <= exec && wr_mem;
      mem_wdata_ff <= res;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (!RST_B)
      flags_ff <= '0;
    else if (exec && upd_arith)
    begin
      flags_ff.carry_flag <= sum[8]; // RULE1 RULE2
      flags_ff.half_carry_flag <= low_sum[4];
      flags_ff.zero_flag <= (sum[7:0] == 8'h00);
      flags_ff.overflow_flag <= (acc_ff[7] == opnd[7]) && (sum[7] != acc_ff[7]);
      flags_ff.secondary_compare_flag <= sum[7] ^ ((acc_ff[7] == opnd[7]) && (sum[7] != acc_ff[7]));
    end
    else if (exec && upd_zero)
      flags_ff.zero_flag <= (res == 8'h00); // RULE3 RULE4 RULE8 RULE11 RULE12
    else if (exec && INSTR.op == OP_DAA)
      flags_ff.carry_flag <= flags_ff.carry_flag | daa_sum[8]; // RULE10
  end

  // watchdog counter and prescaler run freely until cleared by software
  always_ff @(posedge CLK)
  begin
    if (!RST_B)
    begin
      wdt_ff <= '0;
      pre_ff <= '0;
      to_ff <= 1'b0;
      pdf_ff <= 1'b0;
    end
    else if (exec && INSTR.op == OP_WDTCLR)
    begin
      wdt_ff <= '0; // RULE7
      pre_ff <= '0;
      to_ff <= 1'b0;
      pdf_ff <= 1'b0;
    end
    else if (exec && INSTR.op == OP_HALT)
    begin
      wdt_ff <= '0; // RULE13
      pre_ff <= '0;
      to_ff <= 1'b0;
      pdf_ff <= 1'b1;
    end
    else
    begin
      pre_ff <= pre_ff + 8'h01;
      if (pre_ff == 8'hFF)
        wdt_ff <= wdt_ff + 16'h0001;
      if (pre_ff == 8'hFF && wdt_ff == 16'hFFFF)
        to_ff <= 1'b1;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (!RST_B)
      emi_ff <= 1'b0;
    else if (take_irq)
      emi_ff <= 1'b0;
    else if (exec && INSTR.op == OP_INTERRUPT_RETURN)
      emi_ff <= 1'b1; // RULE18
  end

  always_ff @(posedge CLK)
  begin
    if (!RST_B)
      irq_taken_ff <= 1'b0;
    else
      irq_taken_ff <= take_irq;
  end

  assign PC = pc_ff;
  assign ACCUMULATOR = acc_ff;
  assign MEM_WE = mem_we_ff;
  assign MEM_WDATA = mem_wdata_ff;
  assign FLAGS = flags_ff;
  assign WATCHDOG_TIMEOUT_FLAG = to_ff;
  assign POWERDOWN_FLAG = pdf_ff;
  assign GLOBAL_IRQ_ENABLE = emi_ff;
  assign CLK_GATE_OFF = (state_ff == ST_HALTED); // RULE13
  assign WATCHDOG_COUNTER = wdt_ff;
  assign IRQ_TAKEN = irq_taken_ff;
endmodule
`default_nettype wire

/* tb/mcuis_dmem_model.sv */
// one-byte data memory standing behind the core's operand port
`timescale 1ns/1ps
`default_nettype none
module mcuis_dmem_model
(
  input wire logic clk, // clock
  input wire logic we, // write strobe
  input wire logic [7:0] wdata, // write byte
  output logic [7:0] rdata // operand byte
);
  initial rdata = 8'h00;
  always @(posedge clk)
  begin
    if (we)
      rdata <= wdata;
  end
endmodule
`default_nettype wire

/* tb/mcuis_core_assertions.sv */
// concurrent checks on the execution core ports
`timescale 1ns/1ps
`default_nettype none
module mcuis_core_checker
  import mcuis_pkg::*;
(
  input wire logic CLK, // clock
  input wire logic RST_B, // sync reset
  input wire mcuis_instr_t INSTR, // instruction
  input wire logic [7:0] MEM_RDATA, // operand
  input wire logic IRQ_PENDING, // irq pin
  input wire logic WAKE, // wake pin
  input wire logic INSTR_READY, // ready
  input wire logic [12:0] PC, // pc
  input wire logic [7:0] ACCUMULATOR, // acc
  input wire logic MEM_WE, // write strobe
  input wire logic [7:0] MEM_WDATA, // write byte
  input wire mcuis_flags_t FLAGS, // flags
  input wire logic WATCHDOG_TIMEOUT_FLAG, // timeout
  input wire logic POWERDOWN_FLAG, // power-down
  input wire logic GLOBAL_IRQ_ENABLE, // irq enable
  input wire logic CLK_GATE_OFF, // halted
  input wire logic [15:0] WATCHDOG_COUNTER, // watchdog
  input wire logic IRQ_TAKEN // irq entry
);
  logic tk;
  assign tk = INSTR_READY && INSTR.valid;
  default clocking @(posedge CLK);
  endclocking
  default disable iff (!RST_B);
  a_call_target: assert property (tk && INSTR.op == OP_CALL |=> PC == $past(INSTR.target) && !INSTR_READY)
    else $error("call target wrong");
  a_jump_dummy: assert property (tk && INSTR.op == OP_JMP |=> (PC == $past(INSTR.target) && !INSTR_READY)
    ##1 (INSTR_READY || GLOBAL_IRQ_ENABLE))
    else $error("jump timing wrong");
  a_single_cycle: assert property (tk && !GLOBAL_IRQ_ENABLE && INSTR.op inside {OP_NOP, OP_ADC, OP_ADD, OP_AND, OP_OR,
    OP_CLR, OP_CLRB, OP_CPL, OP_DAA, OP_DEC, OP_INC, OP_MOVA, OP_MOVM} |=> INSTR_READY)
    else $error("one-cycle op stalled");
  a_nop_idle: assert property (tk && INSTR.op == OP_NOP |=> $stable(ACCUMULATOR) && $stable(FLAGS) && !MEM_WE
    && PC == $past(PC) + 13'h0001)
    else $error("nop changed state");
  a_logic_zero: assert property (tk && INSTR.op inside {OP_AND, OP_OR} && !INSTR.to_mem |=> FLAGS.zero_flag ==
    (ACCUMULATOR == 8'h00) && $stable({FLAGS.overflow_flag, FLAGS.half_carry_flag, FLAGS.carry_flag}))
    else $error("logic op flags wrong");
  a_flags_kept: assert property (tk && INSTR.op inside {OP_MOVA, OP_MOVM, OP_CLR, OP_CLRB, OP_CALL, OP_JMP, OP_RET}
    |=> $stable(FLAGS))
    else $error("flags changed");
  a_move_store: assert property (tk && INSTR.op == OP_MOVM |=> MEM_WE && MEM_WDATA == $past(ACCUMULATOR))
    else $error("store wrong");
  a_clear_byte: assert property (tk && INSTR.op == OP_CLR |=> MEM_WE && MEM_WDATA == 8'h00)
    else $error("clear wrong");
  a_interrupt_return_enable: assert property (tk && INSTR.op == OP_INTERRUPT_RETURN |=> GLOBAL_IRQ_ENABLE)
    else $error("enable not set");
  a_interrupt_return_pending: assert property (tk && INSTR.op == OP_INTERRUPT_RETURN && IRQ_PENDING && $past(IRQ_PENDING, 3)
    |-> ##[2:6] (IRQ_TAKEN && PC == 13'h0004))
    else $error("pending irq not serviced");
  a_halt_state: assert property (tk && INSTR.op == OP_HALT |=> CLK_GATE_OFF && POWERDOWN_FLAG && !WATCHDOG_TIMEOUT_FLAG
    && WATCHDOG_COUNTER == 16'h0000 && !INSTR_READY)
    else $error("halt state wrong");
  a_wdt_clear: assert property (tk && INSTR.op == OP_WDTCLR |=> !POWERDOWN_FLAG && !WATCHDOG_TIMEOUT_FLAG
    && WATCHDOG_COUNTER == 16'h0000)
    else $error("watchdog clear wrong");
endmodule
bind mcuis_core mcuis_core_checker u_chk (.CLK(CLK), .RST_B(RST_B), .INSTR(INSTR), .MEM_RDATA(MEM_RDATA),
  .IRQ_PENDING(IRQ_PENDING), .WAKE(WAKE), .INSTR_READY(INSTR_READY), .PC(PC), .ACCUMULATOR(ACCUMULATOR),
  .MEM_WE(MEM_WE), .MEM_WDATA(MEM_WDATA), .FLAGS(FLAGS), .WATCHDOG_TIMEOUT_FLAG(WATCHDOG_TIMEOUT_FLAG),
  .POWERDOWN_FLAG(POWERDOWN_FLAG), .GLOBAL_IRQ_ENABLE(GLOBAL_IRQ_ENABLE), .CLK_GATE_OFF(CLK_GATE_OFF),
  .WATCHDOG_COUNTER(WATCHDOG_COUNTER), .IRQ_TAKEN(IRQ_TAKEN));
`default_nettype wire

/* tb/mcuis_core_tb_top.sv */
// self-checking bench for the execution core
`timescale 1ns/1ps
`default_nettype none
module mcuis_core_tb_top;
  import mcuis_pkg::*;
  logic clk = 1'b0, rst_b = 1'b0, irq = 1'b0, wake = 1'b0, rdy, we, gate, pd, to, gie, itk, c9;
  logic [12:0] pc;
  logic [7:0] acc, rd, wd, a, x, r, adj;
  logic [15:0] wdc;
  logic [15:0] bcd[3] = '{16'h1928, 16'h5555, 16'h8090};
  mcuis_flags_t fl, ef = '0;
  mcuis_instr_t ins = '0;
  mcuis_op_t ops[7] = '{OP_ADD, OP_ADC, OP_AND, OP_OR, OP_CPL, OP_INC, OP_DEC};
  logic [7:0] q[$];
  int num_errors = 0, comparisons = 0, seed = 32'h6A630266, i, n, v;
  always #5 clk = ~clk;
  mcuis_core u_dut (.CLK(clk), .RST_B(rst_b), .INSTR(ins), .MEM_RDATA(rd), .IRQ_PENDING(irq), .WAKE(wake),
    .INSTR_READY(rdy), .PC(pc), .ACCUMULATOR(acc), .MEM_WE(we), .MEM_WDATA(wd), .FLAGS(fl),
    .WATCHDOG_TIMEOUT_FLAG(to), .POWERDOWN_FLAG(pd), .GLOBAL_IRQ_ENABLE(gie), .CLK_GATE_OFF(gate),
    .WATCHDOG_COUNTER(wdc), .IRQ_TAKEN(itk));
  mcuis_dmem_model u_mem (.clk(clk), .we(we), .wdata(wd), .rdata(rd));
  task automatic print_verdict;
    if (num_errors == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // every memory write is matched against the oldest expected byte
  always @(negedge clk)
  begin
    if (we === 1'b1)
      cmp({8'h00, wd}, (q.size() > 0) ? {8'h00, q.pop_front()} : 16'hFFFF);
  end
  task automatic run(input mcuis_op_t op, input logic tm, input logic ui, input logic [7:0] im, input logic [12:0] tg);
    @(posedge clk);
    ins <= '{1'b1, op, tm, ui, im, tg[2:0], tg};
    n = 0;
    @(negedge clk);
    while (rdy !== 1'b1 && n < 40)
    begin
      @(negedge clk);
      n++;
    end
    if (rdy !== 1'b1)
    begin
      num_errors++;
      print_verdict;
    end
    @(posedge clk);
    ins.valid <= 1'b0;
    @(posedge clk);
    @(negedge clk);
  endtask
  task automatic alu(input mcuis_op_t op, input logic tm, input logic ui);
    logic [4:0] h;
    h = a[3:0] + x[3:0] + ((op == OP_ADC) ? ef.carry_flag : 1'b0);
    {c9, r} = a + x + ((op == OP_ADC) ? ef.carry_flag : 1'b0);
    case (op)
      OP_AND: r = a & x;
      OP_OR: r = a | x;
      OP_CPL: r = ~x;
      OP_INC: r = x + 8'h01;
      OP_DEC: r = x - 8'h01;
      default: ef = '{(a[7] == x[7]) && (r[7] != a[7]), 1'b0, h[4], c9, r[7] ^ ((a[7] == x[7]) && (r[7] != a[7]))};
    endcase
    ef.zero_flag = (r == 8'h00);
    run(OP_MOVA, 1'b0, 1'b1, x, '0);
    q.push_back(x);
    run(OP_MOVM, 1'b1, 1'b0, 8'h00, '0);
    run(OP_MOVA, 1'b0, 1'b1, a, '0);
    if (tm)
      q.push_back(r);
    run(op, tm, ui, x, '0);
    cmp(fl, ef);
    if (!tm)
    begin
      q.push_back(r);
      run(OP_MOVM, 1'b1, 1'b0, 8'h00, '0);
    end
  endtask
  initial
  begin
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    @(negedge clk);
    cmp(pc, 16'h0000);
    for (i = 0; i < 14; i++)
    begin
      a = $random(seed);
      x = (i >= 12) ? 8'hFF : 8'($random(seed));
      v = $random(seed);
      alu(ops[i % 7], v[0], v[1]);
    end
    for (i = 0; i < 3; i++)
    begin
      {a, x} = bcd[i];
      alu(OP_ADD, 1'b0, 1'b0);
      adj = {((r[7:4] > 4'h9) || ef.carry_flag) ? 4'h6 : 4'h0, ((r[3:0] > 4'h9) || ef.half_carry_flag) ? 4'h6 : 4'h0};
      {c9, r} = r + adj;
      ef.carry_flag = ef.carry_flag | c9;
      q.push_back(r);
      run(OP_DAA, 1'b1, 1'b0, 8'h00, '0);
      cmp(fl, ef);
    end
    q.push_back(8'h00);
    run(OP_CLR, 1'b1, 1'b0, 8'h00, '0);
    x = 8'hFF;
    run(OP_MOVA, 1'b0, 1'b1, x, '0);
    q.push_back(x);
    run(OP_MOVM, 1'b1, 1'b0, 8'h00, '0);
    for (i = 0; i < 8; i++)
    begin
      x[i] = 1'b0;
      q.push_back(x);
      run(OP_CLRB, 1'b1, 1'b0, 8'h00, i[12:0]);
    end
    cmp(fl, ef);
    run(OP_JMP, 1'b0, 1'b0, 8'h00, 13'h0100);
    cmp(pc, 16'h0100);
    run(OP_CALL, 1'b0, 1'b0, 8'h00, 13'h0200);
    cmp(pc, 16'h0200);
    run(OP_RET, 1'b0, 1'b1, 8'h3C, '0);
    cmp(pc, 16'h0101);
    cmp(acc, 16'h003C);
    q.push_back(8'h3C);
    run(OP_MOVM, 1'b1, 1'b0, 8'h00, '0);
    run(OP_CALL, 1'b0, 1'b0, 8'h00, 13'h0300);
    @(posedge clk) irq <= 1'b1;
    repeat (4) @(posedge clk);
    run(OP_INTERRUPT_RETURN, 1'b0, 1'b0, 8'h00, '0);
    for (n = 0; n < 20 && itk !== 1'b1; n++)
      @(negedge clk);
    cmp(itk, 16'h0001);
    if (itk !== 1'b1)
      print_verdict;
    cmp(pc, 16'h0004);
    @(posedge clk) irq <= 1'b0;
    repeat (4) @(posedge clk);
    run(OP_INTERRUPT_RETURN, 1'b0, 1'b0, 8'h00, '0);
    cmp(pc, 16'h0103);
    cmp(gie, 16'h0001);
    run(OP_NOP, 1'b0, 1'b0, 8'h00, '0);
    cmp(pc, 16'h0104);
    run(OP_CALL, 1'b0, 1'b0, 8'h00, 13'h0400);
    run(OP_RET, 1'b0, 1'b0, 8'h55, '0);
    cmp(pc, 16'h0105);
    cmp(acc, 16'h003C);
    run(OP_HALT, 1'b0, 1'b0, 8'h00, '0);
    cmp({gate, pd, to}, 16'h0006);
    cmp(wdc, 16'h0000);
    @(posedge clk) wake <= 1'b1;
    run(OP_WDTCLR, 1'b0, 1'b0, 8'h00, '0);
    @(posedge clk) wake <= 1'b0;
    @(negedge clk);
    cmp({gate, pd, to}, 16'h0000);
    cmp(wdc, 16'h0000);
    cmp(16'(q.size()), 16'h0000);
    print_verdict;
  end
endmodule
`default_nettype wire
